// [cmp_consts.svh]
`ifndef CMP_CONSTS_SVH
`define CMP_CONSTS_SVH
`define CTRL0_ADDR    32'h0000_0000
`define PORT_ADDR     32'h0000_0004
`define BIT_ENABLE    7
`define BIT_RESULT    6
`define BIT_PIN_EN    5
`define BIT_INVERT    4
`define BIT_SPEED     2
`define BIT_HYST      1
`define BIT_SYNC      0
`define CTRL0_RESET   8'h04
`define CTRL0_WMASK   8'hB7
`endif

// [cmp_ctrl.sv]
// How it works
// - uninverted result is one when positive exceeds negative
// - invert bit flips result everywhere
// - pin driven when pin enable and direction clear
// - pin enable clear keeps result internal
// - speed select resets one, one is fast
// - hysteresis bit resets zero, one enables
// - port read returns zero for analog pins
// - enable bit powers comparator and connects inputs
// - latch uses the prescaled timer clock
`timescale 1ns/1ps
`include "cmp_consts.svh"
module cmp_ctrl import cmp_pkg::*; #(
  parameter int PINS = 8
) (
  input  wire logic            clk_i,
  input  wire logic            srst_i,
  input  wire logic [31:0]     haddr_i,
  input  wire logic [1:0]      htrans_i,
  input  wire logic            hwrite_i,
  input  wire logic [2:0]      hsize_i,
  input  wire logic            hsel_i,
  input  wire logic            hready_i,
  input  wire logic [31:0]     hwdata_i,
  output logic [31:0]          hrdata_o,
  output logic                 hreadyout_o,
  output logic                 hresp_o,
  input  wire logic            cmp_raw_i,
  input  wire logic            timer_clk_i,
  input  wire logic [PINS-1:0] pin_level_i,
  input  wire logic [PINS-1:0] pin_analog_i,
  input  wire logic            pin_direction_i,
  output logic                 pin_out_o,
  output logic                 pin_oe_n_o,
  output logic                 timer_result_o,
  output logic                 comparator_enable_o,
  output logic                 speed_power_select_o,
  output logic                 hysteresis_enable_o
);
  // read data is one word, so at most 32 port pins
  if (PINS < 1 || PINS > 32) begin : g_pins_bad
    $error("PINS must be 1..32");
  end

  logic [7:0]    ctrl_r;
  logic          result_r;
  logic          synced_q;
  logic          path_nxt;
  bus_phase_type phase_r;
  logic          wr_r;
  logic [31:0]   addr_r;

  wire cmp_live = cmp_raw_i & ctrl_r[`BIT_ENABLE];
  wire inv_res  = cmp_live ^ ctrl_r[`BIT_INVERT];
  wire take     = hsel_i && hready_i && htrans_i[1];

  // internal result latched every cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) result_r <= 1'b0;
    else        result_r <= inv_res;
  end

  cmp_sync_latch u_sync (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .tick_i (timer_clk_i),
    .d_i    (inv_res),
    .q_o    (synced_q)
  );

  // registered, so the unsynchronised path lags one cycle
  always_comb begin
    path_nxt = ctrl_r[`BIT_SYNC] ? synced_q : inv_res;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_out_o      <= 1'b0;
      pin_oe_n_o     <= 1'b1;
      timer_result_o <= 1'b0;
    end else begin
      timer_result_o <= path_nxt;
      pin_out_o      <= path_nxt;
      // enable bit deliberately not in this term
      pin_oe_n_o <= !(ctrl_r[`BIT_PIN_EN] && !pin_direction_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      comparator_enable_o  <= 1'b0;
      speed_power_select_o <= 1'b1;
      hysteresis_enable_o  <= 1'b0;
    end else begin
      comparator_enable_o  <= ctrl_r[`BIT_ENABLE];
      speed_power_select_o <= ctrl_r[`BIT_SPEED];
      hysteresis_enable_o  <= ctrl_r[`BIT_HYST];
    end
  end

  // bus address phase capture
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      phase_r <= BUS_IDLE;
      wr_r    <= 1'b0;
      addr_r  <= 32'h0000_0000;
    end else if (hready_i) begin
      phase_r <= take ? BUS_DATA : BUS_IDLE;
      wr_r    <= take && hwrite_i;
      addr_r  <= haddr_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_r <= `CTRL0_RESET;
    end else if (phase_r == BUS_DATA && wr_r && addr_r == `CTRL0_ADDR) begin
      ctrl_r <= hwdata_i[7:0] & `CTRL0_WMASK;
    end
  end

  // read data formed in the address phase; zero wait states
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (take && !hwrite_i) begin
      if (haddr_i == `CTRL0_ADDR) begin
        hrdata_o <= {24'h000000, ctrl_r[7], result_r, ctrl_r[5:4], 1'b0, ctrl_r[2:0]};
      end else if (haddr_i == `PORT_ADDR) begin
        hrdata_o <= 32'(pin_level_i & ~pin_analog_i);
      end else begin
        hrdata_o <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hreadyout_o <= 1'b0;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  // values seen at the first edge after release
  a_reset_speed: assert property (@(posedge clk_i)
    $fell(srst_i) |-> speed_power_select_o && !hysteresis_enable_o)
    else $error("bad reset of speed or hysteresis");
  a_oe_reset: assert property (@(posedge clk_i)
    $fell(srst_i) |-> pin_oe_n_o)
    else $error("pin driven straight after reset");

  // pin drive
  a_pin_gate: assert property (@(posedge clk_i) disable iff (srst_i)
    !pin_oe_n_o |-> $past(ctrl_r[`BIT_PIN_EN]) && !$past(pin_direction_i))
    else $error("pin driven without enable");
  a_pin_off: assert property (@(posedge clk_i) disable iff (srst_i)
    !ctrl_r[`BIT_PIN_EN] |=> pin_oe_n_o)
    else $error("pin driven while disabled");
  a_pin_on: assert property (@(posedge clk_i) disable iff (srst_i)
    ctrl_r[`BIT_PIN_EN] && !pin_direction_i |=> !pin_oe_n_o)
    else $error("pin not driven while enabled");

  // result and polarity
  a_polarity: assert property (@(posedge clk_i) disable iff (srst_i)
    1 |=> result_r == (($past(cmp_raw_i) && $past(ctrl_r[`BIT_ENABLE]))
                       != $past(ctrl_r[`BIT_INVERT])))
    else $error("result polarity wrong");
  a_uninv: assert property (@(posedge clk_i) disable iff (srst_i)
    ctrl_r[7] && !ctrl_r[4] && cmp_raw_i ##1 !srst_i |-> result_r)
    else $error("result not one");
  a_disabled: assert property (@(posedge clk_i) disable iff (srst_i)
    !ctrl_r[`BIT_ENABLE] && !ctrl_r[`BIT_INVERT] |=> !result_r)
    else $error("disabled comparator reads one");
  a_invert_idle: assert property (@(posedge clk_i) disable iff (srst_i)
    !ctrl_r[`BIT_ENABLE] && ctrl_r[`BIT_INVERT] |=> result_r)
    else $error("inverted idle result not one");

  // timer and pin path, control outputs
  a_async_path: assert property (@(posedge clk_i) disable iff (srst_i)
    !ctrl_r[`BIT_SYNC] |=> timer_result_o == $past(inv_res))
    else $error("async path wrong");
  a_sync_hold: assert property (@(posedge clk_i) disable iff (srst_i)
    ctrl_r[`BIT_SYNC] && $stable(ctrl_r) && $stable(synced_q)
      |=> timer_result_o == $past(synced_q))
    else $error("sync path wrong");
  a_sync_still: assert property (@(posedge clk_i) disable iff (srst_i)
    ctrl_r[`BIT_SYNC] && !($past(timer_clk_i) && !timer_clk_i) ##1 ctrl_r[`BIT_SYNC]
      |=> $stable(timer_result_o))
    else $error("synchronised result moved without timer fall");
  a_enable_copy: assert property (@(posedge clk_i) disable iff (srst_i)
    1 |=> comparator_enable_o == $past(ctrl_r[`BIT_ENABLE]))
    else $error("enable output does not follow its bit");
  a_power_copy: assert property (@(posedge clk_i) disable iff (srst_i)
    1 |=> speed_power_select_o == $past(ctrl_r[`BIT_SPEED])
      && hysteresis_enable_o == $past(ctrl_r[`BIT_HYST]))
    else $error("speed or hysteresis output wrong");

  // register bus
  a_bit3_zero: assert property (@(posedge clk_i) disable iff (srst_i)
    !ctrl_r[3] && !ctrl_r[6])
    else $error("unimplemented bit stored");
  a_write_lands: assert property (@(posedge clk_i) disable iff (srst_i)
    phase_r == BUS_DATA && wr_r && addr_r == `CTRL0_ADDR
      |=> ctrl_r == ($past(hwdata_i[7:0]) & `CTRL0_WMASK))
    else $error("control write lost");
  a_ctrl_read: assert property (@(posedge clk_i) disable iff (srst_i)
    take && !hwrite_i && haddr_i == `CTRL0_ADDR
      |=> !hrdata_o[3] && hrdata_o[6] == $past(result_r) && hrdata_o[31:8] == 24'h000000)
    else $error("control read wrong");
  a_port_zero: assert property (@(posedge clk_i) disable iff (srst_i)
    take && !hwrite_i && haddr_i == `PORT_ADDR
      |=> (hrdata_o[PINS-1:0] & $past(pin_analog_i)) == '0)
    else $error("analog pin read nonzero");
  a_unmapped_zero: assert property (@(posedge clk_i) disable iff (srst_i)
    take && !hwrite_i && haddr_i != `CTRL0_ADDR && haddr_i != `PORT_ADDR |=> hrdata_o == '0)
    else $error("unmapped read nonzero");
  a_ready_up: assert property (@(posedge clk_i) disable iff (srst_i)
    !$past(srst_i) |-> hreadyout_o && !hresp_o)
    else $error("bus not ready or not okay");

  c_write: cover property (@(posedge clk_i) phase_r == BUS_DATA && wr_r);
  c_pin_drive: cover property (@(posedge clk_i) !pin_oe_n_o);
  c_sync_upd: cover property (@(posedge clk_i) ctrl_r[0] && $changed(synced_q));
  c_port_read: cover property (@(posedge clk_i) take && !hwrite_i && haddr_i == `PORT_ADDR);
  c_inverted: cover property (@(posedge clk_i) ctrl_r[`BIT_INVERT] && result_r);
endmodule

// [cmp_pkg.sv]
package cmp_pkg;
  typedef enum logic {
    BUS_IDLE,
    BUS_DATA
  } bus_phase_type;
endpackage

// [cmp_sync_latch.sv]
`timescale 1ns/1ps
module cmp_sync_latch (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic tick_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic tick_prev_r;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tick_prev_r <= 1'b0;
      q_o         <= 1'b0;
    end else begin
      tick_prev_r <= tick_i;
      // update only on a falling edge of the prescaled timer clock
      if (tick_prev_r && !tick_i) begin
        q_o <= d_i;
      end
    end
  end

  a_latch_hold: assert property (@(posedge clk_i) disable iff (srst_i)
    !(tick_prev_r && !tick_i) |=> $stable(q_o))
    else $error("latch moved without timer fall");
endmodule

// [comparator_control_register_tb_top.sv]
`timescale 1ns/1ps
module comparator_control_register_tb_top;
  logic        clk_i = 1'b0, srst_i = 1'b1, hwrite_i = 1'b0, hsel_i = 1'b1;
  logic        cmp_raw_i = 1'b0, timer_clk_i = 1'b1, pin_direction_i = 1'b0;
  logic [1:0]  htrans_i = 2'h0;
  logic [2:0]  hsize_i  = 3'h2;
  logic [31:0] haddr_i  = 32'h0, hwdata_i = 32'h0, hrdata_o, r;
  logic [7:0]  pin_level_i = 8'h00, pin_analog_i = 8'h00;
  logic        hreadyout_o, hresp_o, pin_out_o, pin_oe_n_o, timer_result_o;
  logic        comparator_enable_o, speed_power_select_o, hysteresis_enable_o;
  int          fails = 0, n_checks = 0;
  always #10 clk_i = ~clk_i;
  cmp_ctrl #(.PINS(8)) DUT (.clk_i(clk_i), .srst_i(srst_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hsel_i(hsel_i),
    .hready_i(hreadyout_o), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .cmp_raw_i(cmp_raw_i),
    .timer_clk_i(timer_clk_i), .pin_level_i(pin_level_i), .pin_analog_i(pin_analog_i),
    .pin_direction_i(pin_direction_i), .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o),
    .timer_result_o(timer_result_o), .comparator_enable_o(comparator_enable_o),
    .speed_power_select_o(speed_power_select_o), .hysteresis_enable_o(hysteresis_enable_o));
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin @(posedge clk_i); k++; end while (hreadyout_o !== 1'b1 && k < 50);
    if (hreadyout_o !== 1'b1) begin fails++; final_report(); end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    haddr_i <= a; hwrite_i <= w; htrans_i <= 2'h2;
    wait_rdy();
    htrans_i <= 2'h0; hwdata_i <= d;
    wait_rdy();
    r = hrdata_o;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string nm);
    xfer(1'b0, a, 32'h0);
    chk(nm, r, exp);
    chk("hresp", {31'h0, hresp_o}, 32'h0);
  endtask
  // registered outputs lag the write by a couple of cycles; sync path by more
  task automatic settle;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic out3(input logic oe_n, input logic po, input logic tr);
    chk("pin_oe_n", {31'h0, pin_oe_n_o}, {31'h0, oe_n});
    chk("pin_out", {31'h0, pin_out_o}, {31'h0, po});
    chk("timer_result", {31'h0, timer_result_o}, {31'h0, tr});
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(32'h0, 32'h04, "ctrl reset");
    chk("speed", {31'h0, speed_power_select_o}, 32'h1);
    xfer(1'b1, 32'h0, 32'hFFFF_FFFF);
    settle();
    rd(32'h0, 32'hF7, "ctrl all ones");
    chk("hyst", {31'h0, hysteresis_enable_o}, 32'h1);
    xfer(1'b1, 32'h0, 32'h0);
    settle();
    rd(32'h0, 32'h00, "ctrl zero");
    chk("speed low", {31'h0, speed_power_select_o}, 32'h0);
    chk("hyst off", {31'h0, hysteresis_enable_o}, 32'h0);
    // polarity and raw level table, pin driven, sync bit clear so async path
    for (int i = 0; i < 4; i++) begin
      cmp_raw_i <= i[0];
      xfer(1'b1, 32'h0, {24'h0, 3'h5, i[1], 4'h0});
      settle();
      rd(32'h0, {24'h0, 1'b1, i[0] ^ i[1], 1'b1, i[1], 4'h0}, "ctrl result");
      out3(1'b0, i[0] ^ i[1], i[0] ^ i[1]);
      chk("enable", {31'h0, comparator_enable_o}, 32'h1);
    end
    // pin override works with comparator off; disabled reads as raw low
    cmp_raw_i <= 1'b1;
    xfer(1'b1, 32'h0, 32'h20);
    settle();
    rd(32'h0, 32'h20, "ctrl disabled");
    chk("enable off", {31'h0, comparator_enable_o}, 32'h0);
    chk("pin_oe_n off", {31'h0, pin_oe_n_o}, 32'h0);
    pin_direction_i <= 1'b1;
    settle();
    chk("pin_oe_n dir", {31'h0, pin_oe_n_o}, 32'h1);
    pin_direction_i <= 1'b0;
    xfer(1'b1, 32'h0, 32'h80);
    settle();
    chk("pin_oe_n internal", {31'h0, pin_oe_n_o}, 32'h1);
    // synchronised: follows raw only at falling edges of the timer clock
    cmp_raw_i <= 1'b0;
    xfer(1'b1, 32'h0, 32'hA1);
    settle();
    cmp_raw_i <= 1'b1;
    settle();
    out3(1'b0, 1'b0, 1'b0);
    timer_clk_i <= 1'b0;
    settle();
    out3(1'b0, 1'b1, 1'b1);
    cmp_raw_i <= 1'b0;
    settle();
    timer_clk_i <= 1'b1;
    settle();
    out3(1'b0, 1'b1, 1'b1);
    timer_clk_i <= 1'b0;
    settle();
    out3(1'b0, 1'b0, 1'b0);
    pin_level_i <= 8'hFF;
    pin_analog_i <= 8'h0F;
    rd(32'h4, 32'hF0, "port analog");
    xfer(1'b1, 32'h8, 32'hFF);
    rd(32'h8, 32'h0, "unmapped");
    rd(32'h0, 32'hA1, "ctrl after unmapped");
    xfer(1'b1, 32'h0, 32'h48);
    settle();
    rd(32'h0, 32'h00, "ctrl read-only bits");
    final_report();
  end
endmodule
